/* File: hw/ssbs_consts.vh */
// constants of the servo stop and brake sequencer
//==========================================================
`ifndef SSBS_CONSTS_VH
`define SSBS_CONSTS_VH
//==========================================================
// wishbone register offsets
`define SSBS_ADR_CTRL 8'h00
`define SSBS_ADR_ON_DLY 8'h04
`define SSBS_ADR_STILL_DLY 8'h08
`define SSBS_ADR_ROT_DLY 8'h0C
`define SSBS_ADR_SPD_THR 8'h10
`define SSBS_ADR_STATUS 8'h14
// control field positions
`define SSBS_CTRL_PHASE 0
`define SSBS_CTRL_SON_STOP 1
`define SSBS_CTRL_C2_STOP 2
`define SSBS_CTRL_LIM_LO 3
`define SSBS_CTRL_LIM_HI 4
// reset values
`define SSBS_CTRL_RST 5'h08
`define SSBS_ON_DLY_RST 10'h0FA
`define SSBS_STILL_DLY_RST 10'h096
`define SSBS_ROT_DLY_RST 10'h1F4
`define SSBS_SPD_THR_RST 12'h01E
// upper limits
`define SSBS_ON_DLY_MAX 10'h1F4
`define SSBS_DLY_MAX 10'h3E8
`define SSBS_SPD_THR_MAX 12'hBB8
// timing
`define SSBS_CLK_HZ 100000000
`define SSBS_TICK_MS 1
`define SSBS_MS_CYCLES ((`SSBS_CLK_HZ / 1000) * `SSBS_TICK_MS)
`endif

/* File: hw/ssbs_ms_tick.v */
// millisecond tick generator
`timescale 1ns/1ns
module ssbs_ms_tick #(
	parameter CYCLES = 100000
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// tick
	output reg tick_o
);
	reg [31:0] cnt_r;
	// free counter, one-cycle pulse per period
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_r <= 32'h0000_0000;
			tick_o <= 1'b0;
		end
		else if (cnt_r == CYCLES - 1)
		begin
			cnt_r <= 32'h0000_0000;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 32'h0000_0001;
			tick_o <= 1'b0;
		end
	end
endmodule

/* File: hw/ssbs_top.v */
// servo stop and brake sequencer with wishbone registers
`timescale 1ns/1ns
`include "ssbs_consts.vh"
module ssbs_top #(
	parameter MS_CYCLES = `SSBS_MS_CYCLES
) (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// drive pins, asynchronous
	input wire son_i,
	input wire fault1_i,
	input wire fault2_i,
	input wire limit_i,
	// speed feedback, same clock
	input wire [11:0] speed_rpm_i,
	// encoder quadrature in, same clock
	input wire enc_a_i,
	input wire enc_b_i,
	// references from motion controller
	input wire ref_vld_i,
	input wire [31:0] ref_i,
	// outputs to power stage and brake
	output reg energize_o,
	output reg brake_rel_o,
	output reg estop_o,
	output reg pos_lock_o,
	output reg ref_vld_o,
	output reg [31:0] ref_o,
	output reg div_a_o,
	output reg div_b_o
);
	//==========================================================
	// state encoding
	localparam ST_OFF = 3'd0;
	localparam ST_ON_WAIT = 3'd1;
	localparam ST_RUN = 3'd2;
	localparam ST_STILL = 3'd3;
	localparam ST_ROT = 3'd4;
	localparam ST_STOP = 3'd5;

	//==========================================================
	// pin synchronisers
	reg [3:0] sync1_r;
	reg [3:0] sync2_r;
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end
		else
		begin
			sync1_r <= {limit_i, fault2_i, fault1_i, son_i};
			sync2_r <= sync1_r;
		end
	end
	wire son_s = sync2_r[0];
	wire f1_s = sync2_r[1];
	wire f2_s = sync2_r[2];
	wire lim_s = sync2_r[3];

	//==========================================================
	// millisecond tick
	wire tick;
	ssbs_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	//==========================================================
	// registers
	reg [4:0] ctrl_r;
	reg [9:0] brake_on_cmd_delay_r;
	reg [9:0] still_dly_r;
	reg [9:0] rot_dly_r;
	reg [11:0] spd_thr_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [9:0] ms_r;
	reg [9:0] ms_nxt;
	// class-two fault caught while the brake output was on
	reg f2_force_r;
	wire limit_stop_sel_zero = (ctrl_r[`SSBS_CTRL_LIM_HI:`SSBS_CTRL_LIM_LO] == 2'd0);
	wire [1:0] limit_stop_sel = ctrl_r[`SSBS_CTRL_LIM_HI:`SSBS_CTRL_LIM_LO];
	wire class2_fault_stop_sel = ctrl_r[`SSBS_CTRL_C2_STOP];
	wire wr = cyc_i & stb_i & we_i & ~ack_o;
	wire rd = cyc_i & stb_i & ~we_i & ~ack_o;

	// register writes, out-of-range values ignored and previous value kept
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_r <= `SSBS_CTRL_RST;
			brake_on_cmd_delay_r <= `SSBS_ON_DLY_RST;
			still_dly_r <= `SSBS_STILL_DLY_RST;
			rot_dly_r <= `SSBS_ROT_DLY_RST;
			spd_thr_r <= `SSBS_SPD_THR_RST;
		end
		else if (wr && sel_i[0])
		begin
			case (adr_i)
				`SSBS_ADR_CTRL:
				begin
					// limit code 3 is illegal, kept at previous value
					ctrl_r[2:0] <= dat_i[2:0];
					if (sel_i[0] && dat_i[4:3] != 2'd3)
						ctrl_r[4:3] <= dat_i[4:3];
				end
				`SSBS_ADR_ON_DLY:
					if (sel_i[1] && dat_i[9:0] <= `SSBS_ON_DLY_MAX)
						brake_on_cmd_delay_r <= dat_i[9:0];
				`SSBS_ADR_STILL_DLY:
					if (sel_i[1] && dat_i[9:0] != 10'h000 && dat_i[9:0] <= `SSBS_DLY_MAX)
						still_dly_r <= dat_i[9:0];
				`SSBS_ADR_ROT_DLY:
					if (sel_i[1] && dat_i[9:0] != 10'h000 && dat_i[9:0] <= `SSBS_DLY_MAX)
						rot_dly_r <= dat_i[9:0];
				`SSBS_ADR_SPD_THR:
					if (sel_i[1] && dat_i[11:0] <= `SSBS_SPD_THR_MAX)
						spd_thr_r <= dat_i[11:0];
				default:
					ctrl_r <= ctrl_r;
			endcase
		end
	end

	// read mux and ack, one wait-state answer
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end
		else
		begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			if (rd)
			begin
				case (adr_i)
					`SSBS_ADR_CTRL: dat_o <= {27'h0000000, ctrl_r};
					`SSBS_ADR_ON_DLY: dat_o <= {22'h000000, brake_on_cmd_delay_r};
					`SSBS_ADR_STILL_DLY: dat_o <= {22'h000000, still_dly_r};
					`SSBS_ADR_ROT_DLY: dat_o <= {22'h000000, rot_dly_r};
					`SSBS_ADR_SPD_THR: dat_o <= {20'h00000, spd_thr_r};
					`SSBS_ADR_STATUS: dat_o <= {16'h0000, ms_r, lim_s, f2_s, f1_s, state_r};
					default: dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	//==========================================================
	// brake and stop sequencer
	wire moving = (speed_rpm_i != 12'h000);
	wire below_thr = (speed_rpm_i < spd_thr_r);
	wire stop_req = ~son_s | f1_s | f2_s | lim_s;
	always @*
	begin
		state_nxt = state_r;
		ms_nxt = ms_r;
		if (tick && ms_r != 10'h000)
			ms_nxt = ms_r - 10'h001;
		case (state_r)
			ST_OFF:
				if (son_s && !f1_s && !f2_s && !lim_s)
				begin
					state_nxt = ST_ON_WAIT;
					ms_nxt = brake_on_cmd_delay_r;
				end
			ST_ON_WAIT:
				if (stop_req)
					state_nxt = ST_OFF;
				else if (ms_r == 10'h000 || ms_r > brake_on_cmd_delay_r)
					state_nxt = ST_RUN;
			ST_RUN:
				if (lim_s && !f1_s && !f2_s && son_s)
				begin
					state_nxt = ST_STOP;
				end
				else if (stop_req)
				begin
					state_nxt = moving ? ST_ROT : ST_STILL;
					ms_nxt = moving ? rot_dly_r : still_dly_r;
				end
			ST_STILL:
				if (ms_r == 10'h000)
					state_nxt = ST_OFF;
			ST_ROT:
				if (below_thr || ms_r == 10'h000)
					state_nxt = ST_OFF;
			ST_STOP:
				if (!lim_s || f1_s || f2_s || !son_s)
					state_nxt = ST_OFF;
			default:
				state_nxt = ST_OFF;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_r <= ST_OFF;
			ms_r <= 10'h000;
		end
		else
		begin
			state_r <= state_nxt;
			ms_r <= ms_nxt;
		end
	end

	// power stage, brake and stop style outputs
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			energize_o <= 1'b0;
			brake_rel_o <= 1'b0;
			estop_o <= 1'b0;
			pos_lock_o <= 1'b0;
			f2_force_r <= 1'b0;
		end
		else
		begin
			// forcing is latched so it outlives the brake dropping during the stop
			if (!f2_s)
				f2_force_r <= 1'b0;
			else if (brake_rel_o)
				f2_force_r <= 1'b1;
			energize_o <= (state_nxt != ST_OFF) && !(state_nxt == ST_STOP && limit_stop_sel_zero);
			// brake stays on while rotating until threshold or delay ends it
			brake_rel_o <= (state_nxt == ST_ON_WAIT) || (state_nxt == ST_RUN) || (state_nxt == ST_STOP)
				|| (state_nxt == ST_ROT);
			pos_lock_o <= (state_nxt == ST_STOP) && (limit_stop_sel == 2'd1);
			if (f1_s)
				estop_o <= 1'b0;
			else if (f2_s)
				estop_o <= class2_fault_stop_sel | brake_rel_o | f2_force_r;
			else if (lim_s)
				estop_o <= ~limit_stop_sel_zero;
			else if (!son_s)
				estop_o <= ctrl_r[`SSBS_CTRL_SON_STOP];
			else
				estop_o <= 1'b0;
		end
	end

	// reference gate, closed outside run
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ref_vld_o <= 1'b0;
			ref_o <= 32'h0000_0000;
		end
		else
		begin
			// closed as soon as run is left, so no reference follows brake off
			ref_vld_o <= ref_vld_i && (state_r == ST_RUN) && (state_nxt == ST_RUN);
			ref_o <= ref_i;
		end
	end

	//==========================================================
	// registered encoder output, not divided, with phase choice
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			div_a_o <= 1'b0;
			div_b_o <= 1'b0;
		end
		else if (ctrl_r[`SSBS_CTRL_PHASE])
		begin
			div_a_o <= enc_b_i;
			div_b_o <= enc_a_i;
		end
		else
		begin
			div_a_o <= enc_a_i;
			div_b_o <= enc_b_i;
		end
	end
endmodule

/* File: dv/ssbs_top_properties.sv */
// assertion checker for the stop and brake sequencer
`timescale 1ns/1ns
module ssbs_checker (
	// watched ports
	input wire clk_i, rst_i, cyc_i, stb_i, ack_o, fault1_i, fault2_i, ref_vld_i, ref_vld_o,
	input wire energize_o, brake_rel_o, estop_o, pos_lock_o, enc_a_i, enc_b_i, div_a_o, div_b_o,
	input wire [11:0] speed_rpm_i
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	//==========================================================
	// bus handshake
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack: assert property (p_ack) else $error("request not acked");
	property p_ack_one; ack_o |=> !ack_o; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	//==========================================================
	// encoder output and sequencing
	property p_div; !$past(rst_i) |-> (div_a_o ^ div_b_o) == $past(enc_a_i ^ enc_b_i); endproperty
	a_div: assert property (p_div) else $error("divided output lost quadrature");
	property p_ref; ref_vld_o |-> $past(ref_vld_i) && brake_rel_o; endproperty
	a_ref: assert property (p_ref) else $error("reference passed while stopped");
	property p_wait; $rose(brake_rel_o) |-> !ref_vld_o [*8]; endproperty
	a_wait: assert property (p_wait) else $error("reference during brake delay");
	property p_f1; fault1_i [*4] |-> !estop_o && !pos_lock_o; endproperty
	a_f1: assert property (p_f1) else $error("class one fault did not coast");
	property p_f2; $rose(fault2_i) && brake_rel_o |-> ##[1:6] estop_o; endproperty
	a_f2: assert property (p_f2) else $error("class two fault not forced to estop");
	property p_still; $fell(brake_rel_o) && energize_o && !estop_o && speed_rpm_i == 12'h000
		|-> energize_o [*8]; endproperty
	a_still: assert property (p_still) else $error("power dropped with brake");
	// main scenarios reached
	c_brake: cover property ($rose(brake_rel_o));
	c_estop: cover property ($rose(estop_o));
	c_lock: cover property ($rose(pos_lock_o));
endmodule
bind ssbs_top ssbs_checker chk_u (.*);

/* File: dv/ssbs_motor_model.sv */
// motor and encoder model driven by the power stage
`timescale 1ns/1ns
module ssbs_motor_model (
	// power stage and bench
	input wire clk_i,
	input wire energize_i,
	input wire estop_i,
	input wire spin_i,
	// feedback
	output logic [11:0] speed_rpm_o = 12'h000,
	output wire enc_a_o,
	output wire enc_b_o
);
	logic [1:0] pos_r = 2'h0;
	// shaft turns only while powered, spin requested and not in estop; the brake output is not modelled
	always @(posedge clk_i)
	begin
		speed_rpm_o <= (energize_i && !estop_i && spin_i) ? 12'h064 : 12'h000;
		if (speed_rpm_o != 12'h000)
			pos_r <= pos_r + 2'h1;
	end
	// gray coded quadrature
	assign enc_a_o = pos_r[1];
	assign enc_b_o = pos_r[1] ^ pos_r[0];
endmodule

/* File: dv/ssbs_top_tb.sv */
// self-checking bench of the stop and brake sequencer
`timescale 1ns/1ns
`include "ssbs_consts.vh"
module ssbs_top_tb;
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, son_i = 0, spin = 0;
	logic fault1_i = 0, fault2_i = 0, limit_i = 0, ref_vld_i = 0, pa, pb;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0, ref_i = 32'h0, rd;
	wire [31:0] dat_o, ref_o;
	wire [11:0] speed_rpm_i;
	wire ack_o, energize_o, brake_rel_o, estop_o, pos_lock_o, ref_vld_o, div_a_o, div_b_o, enc_a_i, enc_b_i;
	int failures = 0, checks = 0, n;
	logic [31:0] cfg [6] = '{32'h00, 32'h09, 32'h10, 32'h17, 32'h08, 32'h0B};
	logic [1:0] exp_r [6] = '{2'h0, 2'h3, 2'h2, 2'h0, 2'h2, 2'h2};
	always #5 clk_i = ~clk_i;
	ssbs_top #(.MS_CYCLES(10)) dut_u (.*);
	ssbs_motor_model mot_u (.clk_i(clk_i), .energize_i(energize_o), .estop_i(estop_o), .spin_i(spin),
		.speed_rpm_o(speed_rpm_i), .enc_a_o(enc_a_i), .enc_b_o(enc_b_i));
	//==========================================================
	// tasks
	task finish_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
		n = 0;
		do @(posedge clk_i) n++; while (ack_o !== 1'b1 && n < 20);
		rd = dat_o;
		{cyc_i, stb_i} <= 2'b00;
		if (n == 20)
		begin
			failures++;
			finish_test();
		end
	endtask
	task rst;
		{rst_i, son_i, fault1_i, fault2_i, limit_i} <= 5'h10;
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
	endtask
	//==========================================================
	// main sequence
	initial
	begin
		n = $urandom(32'h72a1);
		rst();
		wb(0, `SSBS_ADR_CTRL, 0); chk(rd, 32'h8);
		wb(0, `SSBS_ADR_ON_DLY, 0); chk(rd, 32'd250);
		wb(0, `SSBS_ADR_STILL_DLY, 0); chk(rd, 32'd150);
		wb(0, `SSBS_ADR_ROT_DLY, 0); chk(rd, 32'd500);
		wb(0, `SSBS_ADR_SPD_THR, 0); chk(rd, 32'd30);
		wb(1, `SSBS_ADR_CTRL, 32'h18); wb(0, `SSBS_ADR_CTRL, 0); chk(rd, 32'h8);
		wb(1, `SSBS_ADR_ON_DLY, 32'h1F5); wb(0, `SSBS_ADR_ON_DLY, 0); chk(rd, 32'd250);
		wb(1, 8'h40, 32'h1); wb(0, 8'h40, 0); chk(rd, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			// mode 1 of limit stop stands for a vertical axis
			rst();
			wb(1, `SSBS_ADR_CTRL, cfg[i]);
			wb(1, `SSBS_ADR_ON_DLY, 3);
			wb(1, `SSBS_ADR_STILL_DLY, 2);
			spin <= 1;
			son_i <= 1;
			n = 0;
			while (brake_rel_o !== 1'b1 && n < 200) @(posedge clk_i) n++;
			chk(n < 200, 1);
			ref_vld_i <= 1;
			repeat (8) @(posedge clk_i) chk(ref_vld_o, 0);
			repeat (40) @(posedge clk_i);
			repeat (20)
			begin
				ref_i <= $urandom;
				// encoder read once settled, as the next edge will take it
				#1 {pa, pb} = {enc_a_i, enc_b_i};
				@(posedge clk_i);
				#1 chk({div_a_o, div_b_o, ref_vld_o, ref_o}, {i[0] ? {pb, pa} : {pa, pb}, 1'b1, ref_i});
			end
			ref_vld_i <= 0;
			if (i < 3) limit_i <= 1;
			if (i == 3) fault1_i <= 1;
			if (i == 4) fault2_i <= 1;
			if (i == 5) {spin, son_i} <= 2'b00;
			repeat (8) @(posedge clk_i);
			chk(i == 5 ? {energize_o, brake_rel_o} : {estop_o, pos_lock_o}, exp_r[i]);
		end
		finish_test();
	end
	// watchdog
	initial
	begin
		repeat (100000) @(posedge clk_i);
		failures++;
		finish_test();
	end
endmodule
